// file: common/timer_consts.vh
// Register map, field positions and timing constants of the compact timer
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

`define OFS_CLK_PERIOD_CTRL  5'h00
`define OFS_MODE_OUT_CTRL    5'h04
`define OFS_COUNT_LOW        5'h08
`define OFS_COUNT_HIGH       5'h0c
`define OFS_CMPA_LOW         5'h10
`define OFS_CMPA_HIGH        5'h14
`define OFS_INT_FLAGS        5'h18

`define RESET_BYTE           8'h00

`define C0_PAUSE_BIT         7
`define C0_CLKSEL_MSB        6
`define C0_CLKSEL_LSB        4
`define C0_ON_BIT            3
`define C0_PERIOD_MSB        2
`define C0_PERIOD_LSB        0

`define C1_MODE_MSB          7
`define C1_MODE_LSB          6
`define C1_ACT_MSB           5
`define C1_ACT_LSB           4
`define C1_INIT_BIT          3
`define C1_POL_BIT           2
`define C1_SWAP_BIT          1
`define C1_CLRSRC_BIT        0

`define MODE_CMP             2'h0
`define MODE_PWM             2'h2
`define MODE_TMR             2'h3

`define ACT_NONE             2'h0
`define ACT_LOW              2'h1
`define ACT_HIGH             2'h2
`define ACT_TOGGLE           2'h3

`define CK_SYS_DIV4          3'h0
`define CK_SYS               3'h1
`define CK_HIGH_DIV16        3'h2
`define CK_HIGH_DIV64        3'h3
`define CK_SUB_A             3'h4
`define CK_SUB_B             3'h5
`define CK_EXT_RISE          3'h6
`define CK_EXT_FALL          3'h7

`define COUNT_MAX            10'h3ff
`define PRESCALE_W           6

`define AXI_OKAY             2'h0
`define AXI_SLVERR           2'h2

`endif

// file: core/compact_timer.v
// Compact 10-bit timer with compare, PWM and timer modes behind AXI4-Lite
`include "timer_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module compact_timer (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        high_clock_tick,
    input  wire        sub_clock_tick,
    input  wire        external_clock_pin,
    output reg         timer_output_pin,
    output reg         timer_output_pin_inverted,
    output reg         cmp_a_irq,
    output reg         cmp_p_irq
);

    reg  [7:0] ctrl0_reg;
    reg  [7:0] ctrl1_reg;
    reg  [9:0] count_reg;
    reg  [9:0] cmpa_reg;
    reg  [7:0] wbuf_reg;
    reg  [7:0] rbuf_reg;
    reg  [1:0] flags_reg;
    reg        on_d_reg;
    reg        out_reg;
    reg  [`PRESCALE_W-1:0] sys_div_reg;
    reg  [`PRESCALE_W-1:0] high_div_reg;
    reg  [2:0] ext_sync_reg;
    reg        aw_held_reg;
    reg        w_held_reg;
    reg  [4:0] awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0] wstrb_reg;

    wire       pause     = ctrl0_reg[`C0_PAUSE_BIT];
    wire [2:0] clk_sel   = ctrl0_reg[`C0_CLKSEL_MSB:`C0_CLKSEL_LSB];
    wire       timer_on  = ctrl0_reg[`C0_ON_BIT];
    wire [2:0] period_cv = ctrl0_reg[`C0_PERIOD_MSB:`C0_PERIOD_LSB];
    wire [1:0] mode      = ctrl1_reg[`C1_MODE_MSB:`C1_MODE_LSB];
    wire [1:0] pin_act   = ctrl1_reg[`C1_ACT_MSB:`C1_ACT_LSB];
    wire       init_lvl  = ctrl1_reg[`C1_INIT_BIT];
    wire       pol       = ctrl1_reg[`C1_POL_BIT];
    wire       swap      = ctrl1_reg[`C1_SWAP_BIT];
    wire       clr_a     = ctrl1_reg[`C1_CLRSRC_BIT];

    wire on_rise = timer_on & ~on_d_reg;

    // Tick selection; high and sub clock arrive as one-cycle enables
    reg tick;
    always @* begin
        case (clk_sel)
            `CK_SYS_DIV4:   tick = (sys_div_reg[1:0] == 2'h3);
            `CK_SYS:        tick = 1'b1;
            `CK_HIGH_DIV16: tick = high_clock_tick & (high_div_reg[3:0] == 4'hf);
            `CK_HIGH_DIV64: tick = high_clock_tick & (high_div_reg == 6'h3f);
            `CK_SUB_A:      tick = sub_clock_tick;
            `CK_SUB_B:      tick = sub_clock_tick;
            `CK_EXT_RISE:   tick = ext_sync_reg[1] & ~ext_sync_reg[2];
            `CK_EXT_FALL:   tick = ~ext_sync_reg[1] & ext_sync_reg[2];
            default:        tick = 1'b0;
        endcase
    end

    wire run = timer_on & ~pause & ~on_rise;

    // Matches are taken as the counter reaches a value, i.e. on its tick
    wire [9:0] count_inc = count_reg + 10'h001;
    wire       ovf       = run & tick & (count_reg == `COUNT_MAX);
    wire       match_p   = run & tick & (period_cv != 3'h0)
                           & (count_inc[9:7] == period_cv) & (count_inc[6:0] == 7'h00);
    wire       match_a   = run & tick & (cmpa_reg != 10'h000) & (count_inc == cmpa_reg);
    wire       is_pwm    = (mode == `MODE_PWM);
    wire       p_end     = match_p | (ovf & (period_cv == 3'h0));
    wire       clr_by_a  = is_pwm ? swap : clr_a;
    wire       cnt_clear = clr_by_a ? (match_a | ovf) : p_end;
    wire       dir_a     = is_pwm | ~clr_a;
    wire       flag_a    = match_a;
    wire       flag_p    = p_end & dir_a;

    // PWM duty: compare against the non-period comparator
    wire [9:0] duty_val  = swap ? {period_cv, 7'h00} : cmpa_reg;
    wire [9:0] per_len   = swap ? cmpa_reg : {period_cv, 7'h00};
    wire       pwm_act   = (count_reg < duty_val) |
                           ((duty_val >= per_len) & (per_len != 10'h000));

    // Output level before polarity
    reg out_next;
    always @* begin
        out_next = out_reg;
        if (on_rise && mode != `MODE_TMR) begin
            out_next = init_lvl;
        end else if (mode == `MODE_CMP && match_a) begin
            case (pin_act)
                `ACT_LOW:    out_next = 1'b0;
                `ACT_HIGH:   out_next = 1'b1;
                `ACT_TOGGLE: out_next = ~out_reg;
                default:     out_next = out_reg;
            endcase
        end else if (is_pwm) begin
            case (pin_act)
                `ACT_NONE: out_next = ~init_lvl;
                `ACT_LOW:  out_next = init_lvl;
                `ACT_HIGH: out_next = pwm_act ? init_lvl : ~init_lvl;
                default:   out_next = out_reg;
            endcase
        end
    end

    // AXI write path
    wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire [7:0] wbyte = wdata_reg[7:0];
    wire       wb0   = wstrb_reg[0];
    wire       w_ok  = (awaddr_reg == `OFS_CLK_PERIOD_CTRL) |
                       (awaddr_reg == `OFS_MODE_OUT_CTRL) |
                       (awaddr_reg == `OFS_CMPA_LOW) |
                       (awaddr_reg == `OFS_CMPA_HIGH) |
                       (awaddr_reg == `OFS_INT_FLAGS);

    wire rd_take = s_axi_arvalid & s_axi_arready;
    reg [7:0] rbyte;
    reg       r_ok;
    always @* begin
        r_ok = 1'b1;
        case (s_axi_araddr)
            `OFS_CLK_PERIOD_CTRL: rbyte = ctrl0_reg;
            `OFS_MODE_OUT_CTRL:   rbyte = ctrl1_reg;
            `OFS_COUNT_LOW:       rbyte = rbuf_reg;
            `OFS_COUNT_HIGH:      rbyte = {6'h00, count_reg[9:8]};
            `OFS_CMPA_LOW:        rbyte = rbuf_reg;
            `OFS_CMPA_HIGH:       rbyte = {6'h00, cmpa_reg[9:8]};
            `OFS_INT_FLAGS:       rbyte = {6'h00, flags_reg};
            default: begin
                rbyte = `RESET_BYTE;
                r_ok  = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0_reg     <= `RESET_BYTE;
            ctrl1_reg     <= `RESET_BYTE;
            count_reg     <= 10'h000;
            cmpa_reg      <= 10'h000;
            wbuf_reg      <= `RESET_BYTE;
            rbuf_reg      <= `RESET_BYTE;
            flags_reg     <= 2'h0;
            on_d_reg      <= 1'b0;
            out_reg       <= 1'b0;
            sys_div_reg   <= {`PRESCALE_W{1'b0}};
            high_div_reg  <= {`PRESCALE_W{1'b0}};
            ext_sync_reg  <= 3'h0;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= 5'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `AXI_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            timer_output_pin          <= 1'b0;
            timer_output_pin_inverted <= 1'b1;
            cmp_a_irq     <= 1'b0;
            cmp_p_irq     <= 1'b0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], external_clock_pin};
            sys_div_reg  <= sys_div_reg + 6'h01;
            if (high_clock_tick) begin
                high_div_reg <= high_div_reg + 6'h01;
            end
            on_d_reg <= timer_on;

            if (on_rise) begin
                count_reg <= 10'h000;
            end else if (run && tick) begin
                count_reg <= cnt_clear ? 10'h000 : count_inc;
            end

            out_reg <= out_next;
            timer_output_pin          <= out_next ^ pol;
            timer_output_pin_inverted <= ~(out_next ^ pol);
            cmp_a_irq <= flag_a;
            cmp_p_irq <= flag_p;

            // Write address and data taken independently
            s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end

            // Sticky flags: set wins over a write-one clear
            flags_reg <= (flags_reg &
                          ~((do_write && wb0 && awaddr_reg == `OFS_INT_FLAGS) ?
                            wbyte[1:0] : 2'h0)) | {flag_p, flag_a};

            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_ok ? `AXI_OKAY : `AXI_SLVERR;
                if (wb0) begin
                    case (awaddr_reg)
                        `OFS_CLK_PERIOD_CTRL: ctrl0_reg <= wbyte;
                        `OFS_MODE_OUT_CTRL:   ctrl1_reg <= wbyte;
                        `OFS_CMPA_LOW:        wbuf_reg  <= wbyte;
                        `OFS_CMPA_HIGH:       cmpa_reg  <= {wbyte[1:0], wbuf_reg};
                        default:              wbuf_reg  <= wbuf_reg;
                    endcase
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end

            // Read path; high-byte reads latch the low byte into the buffer
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rbyte};
                s_axi_rresp  <= r_ok ? `AXI_OKAY : `AXI_SLVERR;
                if (s_axi_araddr == `OFS_COUNT_HIGH) begin
                    rbuf_reg <= count_reg[7:0];
                end else if (s_axi_araddr == `OFS_CMPA_HIGH) begin
                    rbuf_reg <= cmpa_reg[7:0];
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// file: sim/compact_timer_monitor.sv
// Bus handshake and output pin checks for the compact timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"
module compact_timer_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        timer_output_pin,
    input wire logic        timer_output_pin_inverted,
    input wire logic        cmp_a_irq,
    input wire logic        cmp_p_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_pin_inverse: assert property (timer_output_pin_inverted == !timer_output_pin)
        else $error("inverted pin is not the complement");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready longer than one cycle");
    a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than one cycle");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("unused read bits not zero");
    a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {`AXI_OKAY, `AXI_SLVERR})
        else $error("illegal write response");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    cover property (cmp_a_irq);
    cover property (cmp_p_irq);
    cover property (s_axi_bvalid && s_axi_bresp == `AXI_SLVERR);
endmodule
bind compact_timer compact_timer_monitor u_compact_timer_monitor (.aclk, .aresetn,
    .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .timer_output_pin, .timer_output_pin_inverted, .cmp_a_irq, .cmp_p_irq);
`default_nettype wire

// file: sim/ext_clock_model.sv
// External clock pin source: bursts of pulses, idle low between bursts
`timescale 1ns/1ps
`default_nettype none
module ext_clock_model (
    input  wire logic       aclk,
    input  wire logic [7:0] target,
    output wire logic       ext_pin,
    output wire logic [7:0] sent
);
    logic [2:0] ph = 3'h0;
    logic [7:0] sent_q = 8'h00;
    logic       pin_q = 1'b0;
    assign ext_pin = pin_q;
    assign sent = sent_q;
    always @(posedge aclk) begin
        ph <= ph + 3'h1;
        if (ph == 3'h7 && sent_q != target) sent_q <= sent_q + 8'h01;
        pin_q <= (sent_q != target) && ph[2];
    end
endmodule
`default_nettype wire

// file: sim/compact_timer_test.sv
// Self-checking bench for the compact timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module compact_timer_test;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, x;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, d;
    wire         awready, wready, bvalid, arready, rvalid, ext, pin, pin_n, irq_a, irq_p;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  sent;
    logic        hi_tick = 1'b0, sub_tick = 1'b0;
    logic [7:0]  target;
    logic [1:0]  r;
    logic [9:0]  v, w;
    int          mismatches, checks, g, k, n, cyc = 0;
    int          div [6] = '{16, 4, 128, 512, 32, 32};
    int          win [5] = '{256, 256, 256, 256, 400};
    int          hit [5] = '{64, 192, 0, 256, 256};
    logic [7:0]  pm [5] = '{8'ha8, 8'ha0, 8'h88, 8'h98, 8'haa};
    compact_timer u_compact_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .high_clock_tick(hi_tick), .sub_clock_tick(sub_tick), .external_clock_pin(ext),
        .timer_output_pin(pin), .timer_output_pin_inverted(pin_n), .cmp_a_irq(irq_a),
        .cmp_p_irq(irq_p));
    ext_clock_model u_ext_clock_model (.aclk(aclk), .target(target), .ext_pin(ext), .sent(sent));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        hi_tick <= cyc[0];
        sub_tick <= (cyc[2:0] == 3'h7);
    end
    task summarize;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task tmo;
        mismatches++;
        summarize;
    endtask
    task wr(input logic [4:0] a, input logic [7:0] b, output logic [1:0] rs);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, b};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (i == 40) tmo;
        rs = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [4:0] a, output logic [31:0] q, output logic [1:0] rs);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (i == 40) tmo;
        q = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task rd10(input logic [4:0] a, output logic [9:0] q);
        logic [31:0] h, l;
        rd(a, h, r);
        rd(a - 5'h04, l, r);
        q = {h[1:0], l[7:0]};
    endtask
    task seta(input logic [9:0] a);
        wr(`OFS_CMPA_LOW, a[7:0], r);
        wr(`OFS_CMPA_HIGH, {6'h0, a[9:8]}, r);
    endtask
    task go(input logic [7:0] c0, input logic [7:0] c1);
        wr(`OFS_CLK_PERIOD_CTRL, 8'h00, r);
        wr(`OFS_MODE_OUT_CTRL, c1, r);
        wr(`OFS_CLK_PERIOD_CTRL, c0, r);
    endtask
    task gap(input logic p, output int m);
        int i;
        m = -1;
        for (i = 0; i < 2200; i++) begin
            @(posedge aclk);
            if (m >= 0) m++;
            if ((p ? irq_p : irq_a) === 1'b1) begin
                if (m > 0) break;
                m = 0;
            end
        end
        if (i == 2200) tmo;
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, target} = 50'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (g = 0; g < 6; g++) begin
            rd(5'(g * 4), d, r);
            `CHK(d, 32'h0)
        end
        rd(5'h1c, d, r);
        `CHK(r, `AXI_SLVERR)
        wr(`OFS_COUNT_HIGH, 8'h03, r);
        `CHK(r, `AXI_SLVERR)
        wr(`OFS_MODE_OUT_CTRL, 8'hff, r);
        rd(`OFS_MODE_OUT_CTRL, d, r);
        `CHK(d, 32'hff)
        wr(`OFS_CMPA_LOW, 8'h34, r);
        rd10(`OFS_CMPA_HIGH, v);
        `CHK(v, 10'h000)
        wr(`OFS_CMPA_HIGH, 8'hfe, r);
        rd10(`OFS_CMPA_HIGH, v);
        `CHK(v, 10'h234)
        for (g = 6; g < 8; g++) begin
            go({1'b0, 3'(g), 4'h8}, 8'h00);
            target <= target + 8'd5;
            @(posedge aclk);
            for (k = 0; k < 300 && sent !== target; k++) @(posedge aclk);
            repeat (8) @(posedge aclk);
            rd10(`OFS_COUNT_HIGH, v);
            `CHK(v, 10'd5)
        end
        go(8'h98, 8'h00);
        rd10(`OFS_COUNT_HIGH, v);
        `CHK(v, 10'h000)
        wr(`OFS_CLK_PERIOD_CTRL, 8'h18, r);
        wr(`OFS_CLK_PERIOD_CTRL, 8'h98, r);
        rd10(`OFS_COUNT_HIGH, v);
        rd10(`OFS_COUNT_HIGH, w);
        `CHK(w, v)
        wr(`OFS_CLK_PERIOD_CTRL, 8'h10, r);
        rd10(`OFS_COUNT_HIGH, w);
        `CHK(w, v)
        seta(10'h004);
        for (g = 0; g < 6; g++) begin
            go({1'b0, 3'(g), 4'h8}, 8'h01);
            gap(1'b0, n);
            `CHK(n, div[g])
        end
        for (g = 0; g < 3; g++) begin
            go(8'h18 | 8'(g * 3 % 8), 8'h00);
            gap(1'b1, n);
            `CHK(n, g ? g * 384 % 1024 : 1024)
        end
        rd(`OFS_INT_FLAGS, d, r);
        `CHK(d, 32'h3)
        seta(10'h040);
        for (g = 0; g < 16; g++) begin
            go(8'h18, {2'b00, g[1:0], g[2], g[3], 2'b01});
            repeat (3) @(posedge aclk);
            `CHK(pin, g[2] ^ g[3])
            for (k = 0; k < 200 && irq_a !== 1'b1; k++) @(posedge aclk);
            repeat (3) @(posedge aclk);
            x = g[1] ? (g[0] ? !g[2] : 1'b1) : (g[0] ? 1'b0 : g[2]);
            `CHK(pin, x ^ g[3])
        end
        for (g = 0; g < 5; g++) begin
            seta(g == 4 ? 10'd200 : 10'd32);
            go(8'h19, pm[g]);
            repeat (10) @(posedge aclk);
            n = 0;
            for (k = 0; k < win[g]; k++) begin
                @(posedge aclk);
                if (pin === 1'b1) n++;
            end
            `CHK(n, hit[g])
        end
        summarize;
    end
endmodule
`default_nettype wire
